/* File: logic/stp_baud_gen.sv */
// Purpose: Bit-rate tick from divisor and double-speed setting
// Assumes: Divisor is stable while a frame is sent
// Notes:   Tick is one pclk wide, held off in synchronous mode
`timescale 1ns/1ps
module stp_baud_gen #(
    parameter int DIV_W = stp_pkg::STP_DIV_W
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Settings
    input  wire stp_pkg::stp_cfg_t cfg,
    input  wire logic [DIV_W-1:0] divisor,
    // Bit tick
    output logic                  tick
);
    import stp_pkg::*;

    logic [DIV_W-1:0] pre_q;
    logic [4:0]       ovs_q;
    logic [4:0]       ovs_last;
    logic             tick_q;

    // Double speed halves the samples per bit
    assign ovs_last = 5'((cfg.dbl ? STP_OVS_DBL : STP_OVS_NORM) - 5'h01);

    // Counting up tolerates a divisor change mid-count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q  <= '0;
            ovs_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (cfg.sync) begin
                pre_q <= '0;
                ovs_q <= '0;
            end else if (pre_q >= divisor) begin
                pre_q <= '0;
                if (ovs_q >= ovs_last) begin
                    ovs_q  <= '0;
                    tick_q <= 1'b1;
                end else begin
                    ovs_q <= 5'(ovs_q + 5'h01);
                end
            end else begin
                pre_q <= DIV_W'(pre_q + 1'b1);
            end
        end
    end

    assign tick = tick_q;
endmodule

/* File: logic/stp_sync3.sv */
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Input is asynchronous to pclk
// Notes:   Output changes once stages two and three agree
`timescale 1ns/1ps
module stp_sync3 (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Pin and filtered level
    input  wire logic d,
    output logic      q
);
    import stp_pkg::*;

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic q_q;

    // Stage one feeds stage two only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept a change only when two late stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            q_q <= 1'b0;
        else if (s2_q == s3_q)
            q_q <= s3_q;
    end

    assign q = q_q;
endmodule

/* File: logic/stp_tx_top.sv */
// Purpose: Transmit path of a serial USART with APB registers
// Assumes: Software sets baud, mode and format before sending
// Notes:   One-deep buffer in front of the shift register
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps

// Notes on behaviour
// - Transmit enable hands the serial output pin to the transmitter.
// - Synchronous mode shifts bits on the external transfer clock pin.
// - Writing the data buffer register loads the buffer and starts sending.
// - Buffer moves to shifter at once if idle, else right after last stop.
// - A loaded shifter sends one full frame at the selected bit rate.
// - Unused high bits of short characters are ignored on write.
// - Nine-bit characters send the ninth-bit control value as bit nine.
// - Buffer-empty flag is set while the buffer holds no character.
// - Buffer-empty flag is clear while a character waits in the buffer.
// - Buffer-empty and transmit-complete flags can raise the interrupt.
// - Transmit-complete sets when the frame ends and no character waits.
// - Transmit-complete clears on interrupt service or on a written one.
// - With parity enabled, parity goes between last data and first stop.
// - Disable waits for pending frames, then releases the output pin.
module stp_tx_top (
    // Clock and reset
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    // APB slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [stp_pkg::STP_AW-1:0]    paddr,
    input  wire logic [stp_pkg::STP_DW-1:0]    pwdata,
    output logic      [stp_pkg::STP_DW-1:0]    prdata,
    output logic                               pready,
    output logic                               pslverr,
    // Serial pins
    output logic                               serial_out_pin,
    output logic                               serial_out_oe,
    input  wire logic                          ext_xfer_clock_pin,
    // Interrupt
    output logic                               irq,
    input  wire logic                          txc_int_ack
);
    import stp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    stp_cfg_t               cfg_q;
    stp_stat_t              mask_q;
    stp_stat_t              stat_now;
    stp_stat_t              w1c;
    stp_state_t             state_q;
    logic [STP_DIV_W-1:0]   div_q;
    logic [7:0]             buf_q;
    logic                   buf_full_q;
    logic                   en_eff_q;
    logic                   txc_q;
    logic                   eev_q;
    logic                   irq_q;
    logic [STP_CHR_W-1:0]   shift_q;
    logic [3:0]             bit_cnt_q;
    logic [3:0]             nbits_q;
    logic                   par_q;
    logic                   stop2_q;
    logic                   line_q;
    logic                   xck_prev_q;
    logic [STP_DW-1:0]      prdata_q;
    logic [STP_DW-1:0]      rdata_d;
    logic                   acc_wr;
    logic                   hit_ctrl;
    logic                   hit_stat;
    logic                   hit_mask;
    logic                   hit_data;
    logic                   hit_baud;
    logic                   mapped;
    logic                   baud_tick;
    logic                   xck_s;
    logic                   xck_rise;
    logic                   bit_tick;
    logic                   data_wr;
    logic                   load_idle;
    logic                   last_stop;
    logic                   frame_end;
    logic                   load_b2b;
    logic                   take;
    logic                   txc_set;
    logic                   last_bit;
    logic [3:0]             nb;
    logic [3:0]             nb8;
    logic [7:0]             wmask;
    logic                   nin;
    logic                   par_d;

    // Data bits for a size code; reserved codes act as eight
    function automatic logic [3:0] char_bits(input logic [2:0] csz);
        logic [3:0] n;
        n = STP_BITS_MAX8;
        if (csz == STP_CSZ_NINE)
            n = STP_BITS_NINE;
        else if (csz <= STP_CSZ_MAX8)
            n = 4'(STP_BITS_MIN + {1'b0, csz});
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // APB decode; no wait states
    assign acc_wr   = psel && penable && pwrite;
    assign hit_ctrl = (paddr == STP_OFS_CTRL);
    assign hit_stat = (paddr == STP_OFS_STAT);
    assign hit_mask = (paddr == STP_OFS_MASK);
    assign hit_data = (paddr == STP_OFS_DATA);
    assign hit_baud = (paddr == STP_OFS_BAUD);
    assign mapped   = hit_ctrl || hit_stat || hit_mask || hit_data || hit_baud;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;
    assign prdata   = prdata_q;
    assign w1c      = stp_stat_t'(pwdata[STP_STAT_W-1:0]);

    // Read mux; data register reads as zero
    always_comb begin
        rdata_d = '0;
        case (1'b1)
            hit_ctrl: rdata_d = STP_DW'(cfg_q);
            hit_stat: rdata_d = STP_DW'(stat_now);
            hit_mask: rdata_d = STP_DW'(mask_q);
            hit_baud: rdata_d = STP_DW'(div_q);
            default:  rdata_d = '0;
        endcase
    end

    // Read data captured in setup, stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata_q <= '0;
        else if (psel && !penable && !pwrite)
            prdata_q <= rdata_d;
    end

    // Control, mask and divisor registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q  <= STP_CFG_RST;
            mask_q <= STP_MASK_RST;
            div_q  <= STP_DIV_RST;
        end else if (acc_wr) begin
            if (hit_ctrl)
                cfg_q <= stp_cfg_t'(pwdata[STP_CFG_W-1:0]);
            if (hit_mask)
                mask_q <= stp_stat_t'(pwdata[STP_STAT_W-1:0]);
            if (hit_baud)
                div_q <= pwdata[STP_DIV_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bit timing
    stp_baud_gen #(
        .DIV_W   (STP_DIV_W)
    ) u_baud (
        .pclk    (pclk),
        .presetn (presetn),
        .cfg     (cfg_q),
        .divisor (div_q),
        .tick    (baud_tick)
    );

    stp_sync3 u_xck_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (ext_xfer_clock_pin),
        .q       (xck_s)
    );

    // Edge seen on the filtered pin, never on the first stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            xck_prev_q <= 1'b0;
        else
            xck_prev_q <= xck_s;
    end

    assign xck_rise = xck_s && !xck_prev_q;
    assign bit_tick = cfg_q.sync ? xck_rise : baud_tick;

    ////////////////////////////////////////////////////////////////////////////
    // Transmit buffer
    assign nb      = char_bits(cfg_q.csz);
    assign nb8     = (nb > STP_BITS_MAX8) ? STP_BITS_MAX8 : nb;
    assign wmask   = STP_BYTE_ONES >> (4'(STP_BITS_MAX8 - nb8));
    assign data_wr = acc_wr && hit_data && en_eff_q;

    assign load_idle = (state_q == STP_IDLE) && buf_full_q && en_eff_q;
    assign last_stop = !cfg_q.two_stop || stop2_q;
    assign frame_end = (state_q == STP_STOP) && bit_tick && last_stop;
    assign load_b2b  = frame_end && buf_full_q;
    assign take      = load_idle || load_b2b;
    assign txc_set   = frame_end && !buf_full_q;

    // A write in the cycle of a move keeps the buffer full
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_q      <= '0;
            buf_full_q <= 1'b0;
        end else if (data_wr) begin
            buf_q      <= pwdata[7:0] & wmask;
            buf_full_q <= 1'b1;
        end else if (take) begin
            buf_full_q <= 1'b0;
        end
    end

    // Stays on until shifter and buffer are both drained
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            en_eff_q <= 1'b0;
        else if (cfg_q.tx_en)
            en_eff_q <= 1'b1;
        else if ((state_q == STP_IDLE) && !buf_full_q)
            en_eff_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame sequencer
    assign last_bit = (bit_cnt_q == 4'(nbits_q - 4'h1));

    // ARM waits one tick so the start bit is full length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= STP_IDLE;
        end else begin
            case (state_q)
                STP_IDLE:  if (load_idle) state_q <= STP_ARM;
                STP_ARM:   if (bit_tick) state_q <= STP_START;
                STP_START: if (bit_tick) state_q <= STP_DATA;
                STP_DATA: begin
                    if (bit_tick && last_bit)
                        state_q <= cfg_q.par_en ? STP_PAR : STP_STOP;
                end
                STP_PAR:   if (bit_tick) state_q <= STP_STOP;
                STP_STOP: begin
                    if (frame_end)
                        state_q <= buf_full_q ? STP_START : STP_IDLE;
                end
                default:   state_q <= STP_IDLE;
            endcase
        end
    end

    // Ninth bit taken from control at the move into the shifter
    assign nin   = (cfg_q.csz == STP_CSZ_NINE) ? cfg_q.ninth : 1'b0;
    assign par_d = (^{nin, buf_q}) ^ cfg_q.par_odd;

    // Shift register, bit counter and stop-bit tracking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_q   <= '0;
            bit_cnt_q <= '0;
            nbits_q   <= STP_BITS_MAX8;
            par_q     <= 1'b0;
            stop2_q   <= 1'b0;
        end else if (take) begin
            shift_q   <= {nin, buf_q};
            bit_cnt_q <= '0;
            nbits_q   <= nb;
            par_q     <= par_d;
            stop2_q   <= 1'b0;
        end else if (bit_tick) begin
            if (state_q == STP_DATA) begin
                shift_q   <= shift_q >> 1;
                bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
            end
            if (state_q == STP_STOP)
                stop2_q <= 1'b1;
        end
    end

    // Registered line level; all bits lag the state by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_q <= STP_LINE_IDLE;
        end else begin
            case (state_q)
                STP_START: line_q <= 1'b0;
                STP_DATA:  line_q <= shift_q[0];
                STP_PAR:   line_q <= par_q;
                default:   line_q <= STP_LINE_IDLE;
            endcase
        end
    end

    assign serial_out_pin = line_q;
    assign serial_out_oe  = en_eff_q;

    ////////////////////////////////////////////////////////////////////////////
    // Flags and interrupt
    assign stat_now = '{eev: eev_q, txc: txc_q, empty: !buf_full_q};

    // Set wins over clear; the empty position ignores writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txc_q <= 1'b0;
            eev_q <= 1'b0;
        end else begin
            if (txc_set)
                txc_q <= 1'b1;
            else if (txc_int_ack || (acc_wr && hit_stat && w1c.txc))
                txc_q <= 1'b0;
            if (take && !data_wr)
                eev_q <= 1'b1;
            else if (acc_wr && hit_stat && w1c.eev)
                eev_q <= 1'b0;
        end
    end

    // Level interrupt from any unmasked flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq_q <= 1'b0;
        else
            irq_q <= |(stat_now & mask_q);
    end

    assign irq = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    buf_load_a: assert property (data_wr |=> buf_full_q && !stat_now.empty)
        else $error("buffer not loaded by data write");
    buf_mask_a: assert property (data_wr |=> buf_q == ($past(pwdata[7:0]) & $past(wmask)))
        else $error("unused data bits not dropped");
    idle_move_a: assert property (load_idle && !data_wr |=> state_q == STP_ARM && !buf_full_q)
        else $error("idle shifter did not take buffer");
    b2b_move_a: assert property (load_b2b |=> state_q == STP_START)
        else $error("no back to back frame");
    bit_hold_a: assert property (state_q == STP_DATA && !bit_tick |=> state_q == STP_DATA && $stable(bit_cnt_q))
        else $error("data bit advanced without tick");
    ninth_bit_a: assert property (take && cfg_q.csz == STP_CSZ_NINE |=> shift_q[8] == $past(cfg_q.ninth))
        else $error("ninth bit not from control");
    start_low_a: assert property (state_q == STP_START |=> line_q == 1'b0)
        else $error("start bit not low");
    idle_high_a: assert property (state_q == STP_IDLE |=> line_q == STP_LINE_IDLE)
        else $error("idle line not high");
    parity_bit_a: assert property (state_q == STP_PAR |=> line_q == $past(par_q))
        else $error("parity bit wrong");
    pin_owned_a: assert property (state_q != STP_IDLE |-> serial_out_oe)
        else $error("pin released mid frame");
    late_off_a: assert property ($fell(en_eff_q) |-> $past(state_q) == STP_IDLE && !$past(buf_full_q))
        else $error("disable before drain");
    txc_set_a: assert property (txc_set |=> txc_q ##1 (irq || !$past(mask_q.txc)))
        else $error("complete flag or interrupt missing");
    txc_ack_a: assert property (txc_int_ack && !txc_set |=> !txc_q)
        else $error("complete flag not cleared by service");
    empty_irq_a: assert property (!buf_full_q && mask_q.empty |=> irq)
        else $error("empty interrupt missing");

    back2back_c: cover property (load_b2b);
    parity_c: cover property (state_q == STP_PAR ##1 state_q == STP_STOP);
    nine_bit_c: cover property (take && cfg_q.csz == STP_CSZ_NINE);
    sync_frame_c: cover property (cfg_q.sync && frame_end);
endmodule

/* File: pkg/stp_pkg.sv */
// Purpose: Shared constants and types of the serial transmit path
// Assumes: APB slave with 32-bit data, single clock pclk
// Notes:   Offsets are byte addresses of aligned words
package stp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam int         STP_AW       = 8;
    localparam int         STP_DW       = 32;
    localparam logic [7:0] STP_OFS_CTRL = 8'h00;
    localparam logic [7:0] STP_OFS_STAT = 8'h04;
    localparam logic [7:0] STP_OFS_MASK = 8'h08;
    localparam logic [7:0] STP_OFS_DATA = 8'h0C;
    localparam logic [7:0] STP_OFS_BAUD = 8'h10;

    ////////////////////////////////////////////////////////////////////////////
    // Field widths and codes
    localparam int         STP_DIV_W     = 12;
    localparam int         STP_CFG_W     = 10;
    localparam int         STP_STAT_W    = 3;
    localparam int         STP_CHR_W     = 9;
    localparam logic [2:0] STP_CSZ_MAX8  = 3'h3;
    localparam logic [2:0] STP_CSZ_NINE  = 3'h7;
    localparam logic [3:0] STP_BITS_MIN  = 4'h5;
    localparam logic [3:0] STP_BITS_MAX8 = 4'h8;
    localparam logic [3:0] STP_BITS_NINE = 4'h9;
    localparam logic [7:0] STP_BYTE_ONES = 8'hFF;

    ////////////////////////////////////////////////////////////////////////////
    // Timing: oversampling ticks per bit
    localparam logic [4:0] STP_OVS_NORM = 5'h10;
    localparam logic [4:0] STP_OVS_DBL  = 5'h08;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic [2:0] csz;      // Character size code
        logic       ninth;    // Ninth data bit value
        logic       two_stop; // Two stop bits
        logic       par_odd;  // Odd parity
        logic       par_en;   // Parity enable bit
        logic       dbl;      // Double speed bit
        logic       sync;     // Synchronous mode
        logic       tx_en;    // Transmit enable
    } stp_cfg_t;

    typedef struct packed {
        logic eev;   // Buffer became empty, sticky
        logic txc;   // Transmit complete, sticky
        logic empty; // Buffer empty level
    } stp_stat_t;

    typedef enum logic [5:0] {
        STP_IDLE  = 6'h01,
        STP_ARM   = 6'h02,
        STP_START = 6'h04,
        STP_DATA  = 6'h08,
        STP_PAR   = 6'h10,
        STP_STOP  = 6'h20
    } stp_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam stp_cfg_t             STP_CFG_RST   = '0;
    localparam stp_stat_t            STP_MASK_RST  = '0;
    localparam logic [STP_DIV_W-1:0] STP_DIV_RST   = 12'h000;
    localparam logic                 STP_LINE_IDLE = 1'b1;
endpackage

/* File: verification/stp_rx_model.sv */
// Purpose: Remote serial receiver watching the transmit line
// Assumes: Frames at 16 pclk per bit in every mode the bench uses
// Notes:   Word holds data bits, then parity, then first stop bit
`timescale 1ns/1ps
module stp_rx_model (
    // Clock and line
    input  wire logic        pclk,
    input  wire logic        line,
    // Frame format
    input  wire logic [3:0]  nbits,
    input  wire logic        par_en,
    // Received frame
    output logic      [10:0] rx_word,
    output logic             rx_stb
);
    int i;

    ////////////////////////////////////////////////////////////////////////////
    // Mid-bit sampling after the start edge; passive, never drives the line
    initial begin
        rx_stb  = 1'b0;
        rx_word = '0;
        forever begin
            @(negedge line);
            rx_word = '0;
            repeat (8) @(posedge pclk);
            for (i = 0; i <= nbits + par_en; i++) begin
                repeat (16) @(posedge pclk);
                rx_word[i] = line;
            end
            rx_stb <= 1'b1;
            @(posedge pclk);
            rx_stb <= 1'b0;
        end
    end
endmodule

/* File: verification/stp_tx_top_tb.sv */
// Purpose: Self-checking bench of the serial transmit path
// Assumes: Each mode used gives 16 pclk per bit
// Notes:   Frames judged by the receiver model, flags over APB
`timescale 1ns/1ps
module stp_tx_top_tb;
    import stp_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, ext_run, ack, err;
    logic        ext_clk = 1'b0;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, sout, oe, irq, stb, pe;
    logic [10:0] word;
    logic [3:0]  nb;
    int          n_mismatch, tests_run, t_stb, c;
    int          cyc = 0;

    stp_tx_top u_stp_tx_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_out_pin(sout), .serial_out_oe(oe),
        .ext_xfer_clock_pin(ext_clk), .irq(irq), .txc_int_ack(ack));
    stp_rx_model u_stp_rx_model (.pclk(pclk), .line(sout), .nbits(nb), .par_en(pe),
        .rx_word(word), .rx_stb(stb));

    ////////////////////////////////////////////////////////////////////////////
    // Clock, cycle count, and a transfer clock that stands still when not run
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (ext_run && cyc % 8 == 0) ext_clk <= ~ext_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare, report and closing
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // APB cycle; one idle edge after release so strobes never change twice at once
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        chk(32'(k < 20), 32'h1);
        if (k >= 20) end_of_test();
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Wait for one received frame and compare it with the expected bits
    task automatic frame(input logic [8:0] d, input logic po);
        logic [10:0] e;
        int k;
        e = '0;
        for (k = 0; k < nb; k++) e[k] = d[k];
        if (pe) e[nb] = (^(d & ((9'h1 << nb) - 9'h1))) ^ po;
        e[nb + pe] = 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (stb !== 1'b1 && k < 4000);
        if (k >= 4000) begin
            n_mismatch++;
            end_of_test();
        end
        t_stb = cyc;
        chk(32'(word), 32'(e));
        repeat (16) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {psel, penable, pwrite, ext_run, ack, pe} = '0;
        {paddr, pwdata, n_mismatch, tests_run} = '0;
        nb = 4'h8;
        presetn = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(32'({oe, sout}), 32'h1);
        apb(1'b0, STP_OFS_STAT, 32'h0);
        chk(rd, 32'h1);
        chk(32'(err), 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b1, STP_OFS_BAUD, 32'h0);
        // Character sizes of five to eight bits, upper written bits set
        for (c = 0; c < 4; c++) begin
            nb = 4'(5 + c);
            apb(1'b1, STP_OFS_CTRL, 32'(c << 7) | 32'h1);
            apb(1'b1, STP_OFS_DATA, 32'hFFFF_FF5A);
            chk(32'(oe), 32'h1);
            frame(9'h05A, 1'b0);
        end
        // Even and odd parity
        for (c = 0; c < 2; c++) begin
            pe = 1'b1;
            apb(1'b1, STP_OFS_CTRL, 32'h189 | 32'(c << 4));
            apb(1'b1, STP_OFS_DATA, 32'h5B);
            frame(9'h05B, c[0]);
        end
        // Nine-bit character, ninth bit set before the low byte
        pe = 1'b0;
        nb = 4'h9;
        apb(1'b1, STP_OFS_CTRL, 32'h3C1);
        apb(1'b1, STP_OFS_DATA, 32'h5A);
        frame(9'h15A, 1'b0);
        // Back-to-back characters: no idle gap between frames
        nb = 4'h8;
        apb(1'b1, STP_OFS_CTRL, 32'h181);
        apb(1'b1, STP_OFS_DATA, 32'h33);
        repeat (4) @(posedge pclk);
        apb(1'b0, STP_OFS_STAT, 32'h0);
        chk(rd & 32'h1, 32'h1);
        apb(1'b1, STP_OFS_DATA, 32'hC4);
        apb(1'b0, STP_OFS_STAT, 32'h0);
        chk(rd & 32'h1, 32'h0);
        frame(9'h033, 1'b0);
        c = t_stb;
        frame(9'h0C4, 1'b0);
        chk(32'(t_stb - c), 32'd160);
        // Flags, clearing and interrupt
        apb(1'b0, STP_OFS_STAT, 32'h0);
        chk(rd, 32'h7);
        apb(1'b1, STP_OFS_STAT, 32'h6);
        apb(1'b0, STP_OFS_STAT, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, STP_OFS_MASK, 32'h2);
        apb(1'b1, STP_OFS_DATA, 32'h81);
        chk(32'(irq), 32'h0);
        frame(9'h081, 1'b0);
        chk(32'(irq), 32'h1);
        ack <= 1'b1;
        @(posedge pclk);
        ack <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(32'(irq), 32'h0);
        apb(1'b1, STP_OFS_MASK, 32'h4);
        @(posedge pclk);
        chk(32'(irq), 32'h1);
        apb(1'b1, STP_OFS_STAT, 32'h4);
        @(posedge pclk);
        chk(32'(irq), 32'h0);
        apb(1'b1, STP_OFS_MASK, 32'h1);
        @(posedge pclk);
        chk(32'(irq), 32'h1);
        // Disable during a frame: pin held until the frame ends
        apb(1'b1, STP_OFS_DATA, 32'h96);
        apb(1'b1, STP_OFS_CTRL, 32'h180);
        chk(32'(oe), 32'h1);
        frame(9'h096, 1'b0);
        chk(32'(oe), 32'h0);
        // Double speed at divisor 1 keeps 16 pclk per bit; two stop bits stretch the gap
        apb(1'b1, STP_OFS_BAUD, 32'h1);
        apb(1'b1, STP_OFS_CTRL, 32'h1A5);
        apb(1'b1, STP_OFS_DATA, 32'h3C);
        apb(1'b1, STP_OFS_DATA, 32'hA5);
        frame(9'h03C, 1'b0);
        c = t_stb;
        frame(9'h0A5, 1'b0);
        chk(32'(t_stb - c), 32'd176);
        repeat (16) @(posedge pclk);
        // Synchronous mode: nothing moves until the transfer clock runs
        apb(1'b1, STP_OFS_CTRL, 32'h183);
        apb(1'b1, STP_OFS_DATA, 32'h0F);
        repeat (100) @(posedge pclk);
        chk(32'(sout), 32'h1);
        ext_run <= 1'b1;
        for (c = 0; c < 200 && sout !== 1'b0; c++) @(posedge pclk);
        chk(32'(sout), 32'h0);
        frame(9'h00F, 1'b0);
        end_of_test();
    end
endmodule
